// ===== flash_sr4_defines.svh
`ifndef FLASH_SR4_DEFINES_SVH
`define FLASH_SR4_DEFINES_SVH
// command codes
`define CMD_DEEP_SLEEP   8'hB9
`define CMD_ULTRA_SLEEP  8'h79
`define CMD_RELEASE      8'hAB
`define CMD_SET_WRAP     8'h77
`define CMD_QREAD_A      8'hE7
`define CMD_QREAD_B      8'hEB
`define CMD_WRITE_SR4    8'hC4
`define CMD_READ_SR4     8'hC5
`define CMD_SEQ_PROG     8'hAD
`define CMD_SEQ_EXIT     8'h04
`define CMD_CLEAR_ERR    8'h30
// status register four fields
`define SR4_PDM_BIT      7
`define SR4_SPM_BIT      6
`define SR4_PE_BIT       5
`define SR4_EE_BIT       4
`define SR4_XIP_BIT      3
`define SR4_WRAP_LSB     0
`define SR4_WRAP_RESET   3'h1
`define WRAP_CMD_LSB     4
// frame lengths in link clocks
`define LEN_BYTE         5'h08
`define LEN_ADDR_SINGLE  5'h18
`define LEN_ADDR_QUAD    5'h06
`define LEN_READ_QUAD    5'h03
// host link clock half period in ref_clk cycles
`define SCK_HALF         3'h4
`endif

// ===== flash_sr4_pkg.sv
package flash_sr4_pkg;
  typedef enum logic [2:0] {
    PWR_ON    = 3'h1,
    PWR_DEEP  = 3'h2,
    PWR_ULTRA = 3'h4
  } pwr_state_e;

  typedef enum logic [7:0] {
    ST_START  = 8'h01,
    ST_CMD    = 8'h02,
    ST_ADDRS  = 8'h04,
    ST_ADDRQ  = 8'h08,
    ST_BYTEIN = 8'h10,
    ST_SOUT   = 8'h20,
    ST_QOUT   = 8'h40,
    ST_IGNORE = 8'h80
  } dev_state_e;

  typedef enum logic [5:0] {
    H_IDLE = 6'h01,
    H_CMD  = 6'h02,
    H_ADDR = 6'h04,
    H_WR   = 6'h08,
    H_RD   = 6'h10,
    H_END  = 6'h20
  } host_state_e;

  typedef enum logic [2:0] {
    OP_CMD_ONLY    = 3'h0,
    OP_CMD_WR      = 3'h1,
    OP_CMD_RD      = 3'h2,
    OP_CMD_ADDR_WR = 3'h3,
    OP_QREAD       = 3'h4,
    OP_QREAD_NOCMD = 3'h5
  } host_op_e;
endpackage : flash_sr4_pkg

// ===== spi_link_if.sv
`timescale 1ns/1ps
interface spi_link_if;
  logic       sck;
  logic       cs_n;
  logic [3:0] io_host_out;
  logic [3:0] io_host_oe_n;
  logic [3:0] io_dev_out;
  logic [3:0] io_dev_oe_n;
  logic [3:0] io_wire;

  // weak pull-up keeps an undriven hold line inactive
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (!io_dev_oe_n[i]) io_wire[i] = io_dev_out[i];
      else if (!io_host_oe_n[i]) io_wire[i] = io_host_out[i];
      else io_wire[i] = 1'b1;
    end
  end

  modport device (input sck, input cs_n, input io_wire, output io_dev_out, output io_dev_oe_n);
  modport host (output sck, output cs_n, output io_host_out, output io_host_oe_n, input io_wire);
endinterface : spi_link_if

// ===== sync_bits.sv
`timescale 1ns/1ps
module sync_bits #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : sync_bits

// ===== flash_sr4_device.sv
// Overview of operation
// RULE1 - depth bit 0: deep command gives ultra sleep
// RULE2 - depth bit 1: deep sleep, buffer kept
// RULE3 - only release command wakes from sleep
// RULE4 - sequential flag 0 at reset, 1 once entered
// RULE5 - sequential follow-ups carry command and data only
// RULE6 - program failure sets program fail flag
// RULE7 - erase failure sets erase fail flag
// RULE8 - continuous read: later quad reads skip command
// RULE9 - command on one line, address/data four
// RULE10 - no command-less reads unless both enables set
// RULE11 - wrap field mirrors last wrap command bits
// RULE12 - quad enable turns hold pin into data
// RULE13 - register writes touch only two control bits
`timescale 1ns/1ps
`include "flash_sr4_defines.svh"
module flash_sr4_device (
  // link, clocked by the link clock
  spi_link_if.device link,
  // user clock and reset
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  // failure events and configuration
  input  wire logic       prog_fail,
  input  wire logic       erase_fail,
  input  wire logic       quad_enable_bit,
  // state seen from the user side
  output logic      [7:0] status_out,
  output logic            deep_sleep,
  output logic            ultra_deep_sleep,
  output logic            sram_lost
);
  logic                     pf_tgl_reg;
  logic                     ef_tgl_reg;
  logic                     s_pf;
  logic                     s_ef;
  logic                     s_qe;
  logic                     pf_seen_reg;
  logic                     ef_seen_reg;
  logic                     power_down_depth_select;
  logic                     sequential_program_flag;
  logic                     program_fail_flag;
  logic                     erase_fail_flag;
  logic                     continuous_read_enable;
  logic [2:0]               wrap_setting_mirror;
  logic                     cont_armed_reg;
  logic                     sram_lost_reg;
  logic [23:0]              addr_reg;
  flash_sr4_pkg::pwr_state_e pwr_reg;
  flash_sr4_pkg::dev_state_e st_reg;
  flash_sr4_pkg::dev_state_e eff_st;
  flash_sr4_pkg::dev_state_e cmd_next;
  logic [4:0]               cnt_reg;
  logic [23:0]              sh_reg;
  logic [7:0]               cmd_reg;
  logic [7:0]               tx_reg;
  logic [3:0]               out_reg;
  logic [3:0]               oe_n_reg;
  logic [7:0]               sr4;
  logic [7:0]               shift_w;
  logic [23:0]              qaddr_w;
  logic                     frame_rst_n;
  logic                     hold;
  logic                     cmd_done;
  logic                     byte_done;
  logic                     addrq_done;
  logic                     addrs_done;
  logic                     fail_p;
  logic                     fail_e;
  logic                     clear_err;

  // user side: events become toggles so a stopped link clock loses none
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pf_tgl_reg <= 1'b0;
      ef_tgl_reg <= 1'b0;
    end else begin
      if (prog_fail) pf_tgl_reg <= ~pf_tgl_reg;
      if (erase_fail) ef_tgl_reg <= ~ef_tgl_reg;
    end
  end

  sync_bits #(.W(3)) u_to_link (
    .clk    (link.sck),
    .arst_n (arst_n),
    .d      ({pf_tgl_reg, ef_tgl_reg, quad_enable_bit}),
    .q      ({s_pf, s_ef, s_qe})
  );

  // state back to ref_clk; fields are independent levels
  sync_bits #(.W(11)) u_to_user (
    .clk    (ref_clk),
    .arst_n (arst_n),
    .d      ({sr4, pwr_reg == flash_sr4_pkg::PWR_DEEP, pwr_reg == flash_sr4_pkg::PWR_ULTRA,
              sram_lost_reg}),
    .q      ({status_out, deep_sleep, ultra_deep_sleep, sram_lost})
  );

  assign sr4 = {power_down_depth_select, sequential_program_flag, program_fail_flag,
                erase_fail_flag, continuous_read_enable, wrap_setting_mirror};
  assign frame_rst_n = arst_n & ~link.cs_n;
  assign hold = ~s_qe & ~link.io_wire[3]; // RULE12
  assign shift_w = {sh_reg[6:0], link.io_wire[0]};
  assign qaddr_w = {sh_reg[19:0], link.io_wire};

  // frame decode
  always_comb begin
    eff_st = st_reg;
    if (st_reg == flash_sr4_pkg::ST_START)
      eff_st = cont_armed_reg ? flash_sr4_pkg::ST_ADDRQ : flash_sr4_pkg::ST_CMD; // RULE8
    cmd_done   = ~hold & (eff_st == flash_sr4_pkg::ST_CMD) & (cnt_reg == 5'h07);
    byte_done  = ~hold & (eff_st == flash_sr4_pkg::ST_BYTEIN) & (cnt_reg == 5'h07);
    addrq_done = ~hold & (eff_st == flash_sr4_pkg::ST_ADDRQ) & (cnt_reg == 5'h05);
    addrs_done = ~hold & (eff_st == flash_sr4_pkg::ST_ADDRS) & (cnt_reg == 5'h17);
    clear_err  = cmd_done & (pwr_reg == flash_sr4_pkg::PWR_ON) & (shift_w == `CMD_CLEAR_ERR);
    fail_p     = s_pf != pf_seen_reg;
    fail_e     = s_ef != ef_seen_reg;
  end

  always_comb begin
    cmd_next = flash_sr4_pkg::ST_IGNORE;
    if (pwr_reg == flash_sr4_pkg::PWR_ON) begin
      case (shift_w)
        `CMD_WRITE_SR4, `CMD_SET_WRAP: cmd_next = flash_sr4_pkg::ST_BYTEIN;
        `CMD_READ_SR4:                 cmd_next = flash_sr4_pkg::ST_SOUT;
        `CMD_QREAD_A, `CMD_QREAD_B:    cmd_next = flash_sr4_pkg::ST_ADDRQ; // RULE9
        `CMD_SEQ_PROG: cmd_next = sequential_program_flag ? flash_sr4_pkg::ST_BYTEIN // RULE5
                                                           : flash_sr4_pkg::ST_ADDRS;
        default:                       cmd_next = flash_sr4_pkg::ST_IGNORE;
      endcase
    end
  end

  // frame engine; chip select high returns it to the start
  always_ff @(posedge link.sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      st_reg   <= flash_sr4_pkg::ST_START;
      cnt_reg  <= 5'h00;
      sh_reg   <= 24'h000000;
      cmd_reg  <= 8'h00;
      tx_reg   <= 8'h00;
      out_reg  <= 4'hF;
      oe_n_reg <= 4'hF;
    end else if (!hold) begin
      cnt_reg <= cnt_reg + 5'h01;
      case (eff_st)
        flash_sr4_pkg::ST_CMD: begin
          sh_reg <= {sh_reg[22:0], link.io_wire[0]}; // RULE9
          st_reg <= flash_sr4_pkg::ST_CMD;
          if (cmd_done) begin
            cnt_reg <= 5'h00;
            cmd_reg <= shift_w;
            st_reg  <= cmd_next;
            if (cmd_next == flash_sr4_pkg::ST_SOUT) begin
              out_reg[1] <= sr4[7];
              tx_reg     <= {sr4[6:0], 1'b0};
              oe_n_reg   <= 4'hD;
            end
          end
        end
        flash_sr4_pkg::ST_ADDRQ: begin
          sh_reg <= {sh_reg[19:0], link.io_wire};
          st_reg <= flash_sr4_pkg::ST_ADDRQ;
          if (addrq_done) begin
            // one turnaround clock so both ends never drive together
            st_reg  <= flash_sr4_pkg::ST_QOUT;
            cnt_reg <= 5'h00;
          end
        end
        flash_sr4_pkg::ST_ADDRS: begin
          sh_reg <= {sh_reg[22:0], link.io_wire[0]};
          if (addrs_done) begin
            st_reg  <= flash_sr4_pkg::ST_BYTEIN;
            cnt_reg <= 5'h00;
          end
        end
        flash_sr4_pkg::ST_BYTEIN: begin
          sh_reg <= {sh_reg[22:0], link.io_wire[0]};
          if (byte_done) begin
            cnt_reg <= 5'h00;
            if (cmd_reg != `CMD_SEQ_PROG) st_reg <= flash_sr4_pkg::ST_IGNORE;
          end
        end
        flash_sr4_pkg::ST_SOUT: begin
          out_reg[1] <= tx_reg[7];
          tx_reg     <= {tx_reg[6:0], 1'b0};
        end
        flash_sr4_pkg::ST_QOUT: begin
          if (cnt_reg[0]) begin
            out_reg <= tx_reg[7:4];
          end else begin
            out_reg  <= addr_reg[7:4];
            tx_reg   <= {addr_reg[3:0], 4'h0};
            oe_n_reg <= 4'h0;
          end
        end
        default: st_reg <= flash_sr4_pkg::ST_IGNORE;
      endcase
    end
  end

  assign link.io_dev_out  = out_reg;
  assign link.io_dev_oe_n = oe_n_reg;

  // power state: sleep commands ignored unless awake, release only wakes
  always_ff @(posedge link.sck or negedge arst_n) begin
    if (!arst_n) begin
      pwr_reg       <= flash_sr4_pkg::PWR_ON;
      sram_lost_reg <= 1'b0;
    end else if (cmd_done) begin
      if (pwr_reg != flash_sr4_pkg::PWR_ON) begin
        if (shift_w == `CMD_RELEASE) pwr_reg <= flash_sr4_pkg::PWR_ON; // RULE3
      end else if (shift_w == `CMD_ULTRA_SLEEP ||
                   (shift_w == `CMD_DEEP_SLEEP && !power_down_depth_select)) begin
        pwr_reg       <= flash_sr4_pkg::PWR_ULTRA; // RULE1
        sram_lost_reg <= 1'b1; // RULE1
      end else if (shift_w == `CMD_DEEP_SLEEP) begin
        pwr_reg <= flash_sr4_pkg::PWR_DEEP; // RULE2
      end
    end else if (byte_done && cmd_reg == `CMD_SEQ_PROG) begin
      sram_lost_reg <= 1'b0;
    end
  end

  // sequential mode flag; exit command returns to byte/page mode
  always_ff @(posedge link.sck or negedge arst_n) begin
    if (!arst_n) begin
      sequential_program_flag <= 1'b0; // RULE4
    end else if (cmd_done && pwr_reg == flash_sr4_pkg::PWR_ON) begin
      if (shift_w == `CMD_SEQ_PROG) sequential_program_flag <= 1'b1; // RULE4
      else if (shift_w == `CMD_SEQ_EXIT) sequential_program_flag <= 1'b0;
    end
  end

  // failure flags: a set in the clearing edge wins
  always_ff @(posedge link.sck or negedge arst_n) begin
    if (!arst_n) begin
      pf_seen_reg       <= 1'b0;
      ef_seen_reg       <= 1'b0;
      program_fail_flag <= 1'b0;
      erase_fail_flag   <= 1'b0;
    end else begin
      pf_seen_reg       <= s_pf;
      ef_seen_reg       <= s_ef;
      program_fail_flag <= fail_p | (program_fail_flag & ~clear_err); // RULE6
      erase_fail_flag   <= fail_e | (erase_fail_flag & ~clear_err); // RULE7
    end
  end

  // control bits and wrap mirror
  always_ff @(posedge link.sck or negedge arst_n) begin
    if (!arst_n) begin
      power_down_depth_select <= 1'b0;
      continuous_read_enable  <= 1'b0;
      wrap_setting_mirror     <= `SR4_WRAP_RESET;
    end else if (byte_done && cmd_reg == `CMD_WRITE_SR4) begin
      power_down_depth_select <= shift_w[`SR4_PDM_BIT]; // RULE13
      continuous_read_enable  <= shift_w[`SR4_XIP_BIT]; // RULE13
    end else if (byte_done && cmd_reg == `CMD_SET_WRAP) begin
      wrap_setting_mirror <= shift_w[`WRAP_CMD_LSB +: 3]; // RULE11
    end
  end

  // continuous read arms after a quad read, drops when either enable drops
  always_ff @(posedge link.sck or negedge arst_n) begin
    if (!arst_n) begin
      cont_armed_reg <= 1'b0;
    end else if (!(continuous_read_enable && s_qe)) begin
      cont_armed_reg <= 1'b0; // RULE10
    end else if (cmd_done && cmd_next == flash_sr4_pkg::ST_ADDRQ) begin
      cont_armed_reg <= 1'b1; // RULE8
    end
  end

  // internal address, continued across sequential transfers, reloaded by the address phase of each quad transfer
  always_ff @(posedge link.sck or negedge arst_n) begin
    if (!arst_n) begin
      addr_reg <= 24'h000000;
    end else if (addrq_done) begin
      addr_reg <= qaddr_w;
    end else if (addrs_done) begin
      addr_reg <= {sh_reg[22:0], link.io_wire[0]};
    end else if (byte_done && cmd_reg == `CMD_SEQ_PROG) begin
      addr_reg <= addr_reg + 24'h000001; // RULE5
    end else if (!hold && eff_st == flash_sr4_pkg::ST_QOUT && !cnt_reg[0]) begin
      addr_reg <= addr_reg + 24'h000001;
    end
  end
endmodule : flash_sr4_device

// ===== flash_sr4_host.sv
`timescale 1ns/1ps
`include "flash_sr4_defines.svh"
module flash_sr4_host (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  // request
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  flash_sr4_pkg::host_op_e req_op,
  input  wire logic        [7:0] req_cmd,
  input  wire logic       [23:0] req_addr,
  input  wire logic        [7:0] req_data,
  // answer
  output logic                   rsp_valid,
  output logic             [7:0] rsp_data,
  // link
  spi_link_if.host               link
);
  flash_sr4_pkg::host_state_e st_reg;
  flash_sr4_pkg::host_op_e    op_reg;
  logic [2:0]                div_reg;
  logic                      sck_reg;
  logic                      cs_n_reg;
  logic [4:0]                cnt_reg;
  logic [31:0]               tx_reg;
  logic [7:0]                rx_reg;
  logic [7:0]                cmd_reg;
  logic [23:0]               addr_reg;
  logic [7:0]                data_reg;
  logic [3:0]                io_out_reg;
  logic [3:0]                oe_n_reg;
  logic [3:0]                io_s;
  logic                      tick;
  logic                      rise;
  logic                      fall;
  logic                      quad;

  sync_bits #(.W(4)) u_rx_sync (
    .clk    (ref_clk),
    .arst_n (arst_n),
    .d      (link.io_wire),
    .q      (io_s)
  );

  function automatic flash_sr4_pkg::host_state_e after_phase(
      flash_sr4_pkg::host_state_e s, flash_sr4_pkg::host_op_e op);
    case (s)
      flash_sr4_pkg::H_IDLE:
        return (op == flash_sr4_pkg::OP_QREAD_NOCMD) ? flash_sr4_pkg::H_ADDR // RULE8
                                                     : flash_sr4_pkg::H_CMD;
      flash_sr4_pkg::H_CMD: begin
        if (op == flash_sr4_pkg::OP_CMD_ONLY) return flash_sr4_pkg::H_END;
        if (op == flash_sr4_pkg::OP_CMD_WR) return flash_sr4_pkg::H_WR; // RULE5
        if (op == flash_sr4_pkg::OP_CMD_RD) return flash_sr4_pkg::H_RD;
        return flash_sr4_pkg::H_ADDR;
      end
      flash_sr4_pkg::H_ADDR:
        return (op == flash_sr4_pkg::OP_CMD_ADDR_WR) ? flash_sr4_pkg::H_WR
                                                     : flash_sr4_pkg::H_RD;
      default: return flash_sr4_pkg::H_END;
    endcase
  endfunction : after_phase

  function automatic logic is_quad(flash_sr4_pkg::host_state_e s, flash_sr4_pkg::host_op_e op);
    return (s == flash_sr4_pkg::H_ADDR || s == flash_sr4_pkg::H_RD) &&
           (op == flash_sr4_pkg::OP_QREAD || op == flash_sr4_pkg::OP_QREAD_NOCMD); // RULE9
  endfunction : is_quad

  assign tick = (div_reg == `SCK_HALF - 3'h1);
  assign rise = tick & ~sck_reg & ~cs_n_reg & (st_reg != flash_sr4_pkg::H_END);
  assign fall = tick & sck_reg;
  assign quad = is_quad(st_reg, op_reg);
  assign req_ready = (st_reg == flash_sr4_pkg::H_IDLE);

  // link clock divider; runs only inside a frame
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_reg <= 3'h0;
      sck_reg <= 1'b0;
    end else if (cs_n_reg) begin
      div_reg <= 3'h0;
      sck_reg <= 1'b0;
    end else begin
      div_reg <= tick ? 3'h0 : div_reg + 3'h1;
      if (rise) sck_reg <= 1'b1;
      else if (fall) sck_reg <= 1'b0;
    end
  end

  // frame sequencer: drive after falling edge, sample at rising edge
  always_ff @(posedge ref_clk or negedge arst_n) begin
    flash_sr4_pkg::host_state_e nx;
    logic [31:0]                ld;
    logic                       nq;
    nx = flash_sr4_pkg::H_IDLE;
    ld = 32'h00000000;
    nq = 1'b0;
    if (!arst_n) begin
      st_reg     <= flash_sr4_pkg::H_IDLE;
      op_reg     <= flash_sr4_pkg::OP_CMD_ONLY;
      cs_n_reg   <= 1'b1;
      cnt_reg    <= 5'h00;
      tx_reg     <= 32'h00000000;
      rx_reg     <= 8'h00;
      cmd_reg    <= 8'h00;
      addr_reg   <= 24'h000000;
      data_reg   <= 8'h00;
      io_out_reg <= 4'hF;
      oe_n_reg   <= 4'hF;
      rsp_valid  <= 1'b0;
      rsp_data   <= 8'h00;
    end else begin
      rsp_valid <= 1'b0;
      if ((st_reg == flash_sr4_pkg::H_IDLE && req_valid) || (fall && cnt_reg == 5'h01)) begin
        nx = (st_reg == flash_sr4_pkg::H_IDLE) ? after_phase(st_reg, req_op)
                                               : after_phase(st_reg, op_reg);
        if (st_reg == flash_sr4_pkg::H_IDLE) begin
          op_reg   <= req_op;
          cmd_reg  <= req_cmd;
          addr_reg <= req_addr;
          data_reg <= req_data;
          cs_n_reg <= 1'b0;
          nq = is_quad(nx, req_op);
          ld = (nx == flash_sr4_pkg::H_CMD) ? {req_cmd, 24'h000000} : {req_addr, 8'h00};
        end else begin
          nq = is_quad(nx, op_reg);
          ld = (nx == flash_sr4_pkg::H_WR) ? {data_reg, 24'h000000} : {addr_reg, 8'h00};
        end
        st_reg <= nx;
        tx_reg <= ld;
        case (nx)
          flash_sr4_pkg::H_ADDR: cnt_reg <= nq ? `LEN_ADDR_QUAD : `LEN_ADDR_SINGLE;
          flash_sr4_pkg::H_RD:   cnt_reg <= nq ? `LEN_READ_QUAD : `LEN_BYTE;
          default:               cnt_reg <= `LEN_BYTE;
        endcase
        io_out_reg <= nq ? ld[31:28] : {3'h7, ld[31]};
        if (nx == flash_sr4_pkg::H_RD || nx == flash_sr4_pkg::H_END) oe_n_reg <= 4'hF;
        else oe_n_reg <= nq ? 4'h0 : 4'hE;
      end else if (fall) begin
        cnt_reg    <= cnt_reg - 5'h01;
        tx_reg     <= quad ? {tx_reg[27:0], 4'h0} : {tx_reg[30:0], 1'b0};
        io_out_reg <= quad ? tx_reg[27:24] : {3'h7, tx_reg[30]};
      end else if (st_reg == flash_sr4_pkg::H_END && tick) begin
        // one half period of select hold after the last falling edge, then deselect
        st_reg    <= flash_sr4_pkg::H_IDLE;
        cs_n_reg  <= 1'b1;
        rsp_valid <= (op_reg != flash_sr4_pkg::OP_CMD_ONLY) && (op_reg != flash_sr4_pkg::OP_CMD_WR)
                     && (op_reg != flash_sr4_pkg::OP_CMD_ADDR_WR);
        rsp_data  <= rx_reg;
      end
      if (rise && st_reg == flash_sr4_pkg::H_RD)
        rx_reg <= quad ? {rx_reg[3:0], io_s} : {rx_reg[6:0], io_s[1]};
    end
  end

  assign link.sck          = sck_reg;
  assign link.cs_n         = cs_n_reg;
  assign link.io_host_out  = io_out_reg;
  assign link.io_host_oe_n = oe_n_reg;
endmodule : flash_sr4_host

// ===== flash_status_reg4_ctrl_chk.sv
`timescale 1ns/1ps
module flash_status_reg4_ctrl_chk (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       arst_n,
  // link
  input wire logic       sck,
  input wire logic       cs_n,
  input wire logic [3:0] io_host_out,
  input wire logic [3:0] io_host_oe_n,
  input wire logic [3:0] io_dev_out,
  input wire logic [3:0] io_dev_oe_n,
  input wire logic [3:0] io_wire
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_sck_idle_low: assert property (cs_n |-> !sck)
    else $error("sck high outside a frame");
  a_sck_half_four: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
    else $error("sck high phase not four cycles");
  a_frame_clock_starts: assert property ($fell(cs_n) |-> ##[1:4] $rose(sck))
    else $error("no sck soon after select");
  a_host_moves_low: assert property ($changed(io_host_out) |-> !sck)
    else $error("host data moved while sck high");
  a_dev_moves_high: assert property (!cs_n && $changed(io_dev_out) |-> sck)
    else $error("device data moved while sck low");
  a_no_contention: assert property ((io_host_oe_n | io_dev_oe_n) == 4'hF)
    else $error("both ends drive one line");
  a_dev_line_group: assert property (io_dev_oe_n inside {4'hF, 4'hD, 4'h0})
    else $error("device drives an odd set of lines");
  a_host_line_group: assert property (io_host_oe_n inside {4'hF, 4'hE, 4'h0})
    else $error("host drives an odd set of lines");
  // after three deselected cycles neither end may drive the lines
  a_idle_released: assert property (cs_n [*3] |-> (io_dev_oe_n & io_host_oe_n) == 4'hF)
    else $error("line driven outside a frame");
  c_frame: cover property ($fell(cs_n));
  c_status_out: cover property (io_dev_oe_n == 4'hD);
  c_quad_out: cover property (io_dev_oe_n == 4'h0);
  c_no_cmd: cover property ($fell(cs_n) ##1 io_host_oe_n == 4'h0);
endmodule : flash_status_reg4_ctrl_chk

// ===== tb_flash_status_reg4_ctrl.sv
`timescale 1ns/1ps
`include "flash_sr4_defines.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb_flash_status_reg4_ctrl;
  logic                    ref_clk = 1'b0;
  logic                    arst_n = 1'b1;
  logic                    req_valid = 1'b0;
  logic                    req_ready;
  flash_sr4_pkg::host_op_e req_op = flash_sr4_pkg::OP_CMD_ONLY;
  logic [7:0]              req_cmd = 8'h00;
  logic [23:0]             req_addr = 24'h000000;
  logic [7:0]              req_data = 8'h00;
  logic                    rsp_valid;
  logic [7:0]              rsp_data;
  logic                    prog_fail = 1'b0;
  logic                    erase_fail = 1'b0;
  logic                    quad_enable_bit = 1'b0;
  logic [7:0]              status_out;
  logic                    deep_sleep;
  logic                    ultra_deep_sleep;
  logic                    sram_lost;
  logic [7:0]              sr = 8'h01;
  logic [7:0]              e_now;
  logic [7:0]              exp_q[$];
  logic [31:0]             seed = 32'h0001834F;
  logic [7:0]              pd_d[3] = '{8'h80, 8'h00, 8'h00};
  logic [7:0]              pd_c[3] = '{`CMD_DEEP_SLEEP, `CMD_DEEP_SLEEP, `CMD_ULTRA_SLEEP};
  logic [2:0]              pd_e[3] = '{3'h4, 3'h3, 3'h3};
  int                      fails = 0;
  int                      check_count = 0;
  int                      cyc = 0;

  always #2.5 ref_clk = ~ref_clk;

  spi_link_if link ();
  flash_sr4_host u_flash_sr4_host (.ref_clk(ref_clk), .arst_n(arst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_cmd(req_cmd), .req_addr(req_addr),
    .req_data(req_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .link(link));
  flash_sr4_device u_flash_sr4_device (.link(link), .ref_clk(ref_clk), .arst_n(arst_n),
    .prog_fail(prog_fail), .erase_fail(erase_fail), .quad_enable_bit(quad_enable_bit),
    .status_out(status_out), .deep_sleep(deep_sleep), .ultra_deep_sleep(ultra_deep_sleep),
    .sram_lost(sram_lost));
  flash_status_reg4_ctrl_chk u_flash_status_reg4_ctrl_chk (.ref_clk(ref_clk), .arst_n(arst_n),
    .sck(link.sck), .cs_n(link.cs_n), .io_host_out(link.io_host_out),
    .io_host_oe_n(link.io_host_oe_n), .io_dev_out(link.io_dev_out),
    .io_dev_oe_n(link.io_dev_oe_n), .io_wire(link.io_wire));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0 && exp_q.size() == 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report

  // ready is combinational, so it is looked at on the falling edge
  task automatic xfer(input flash_sr4_pkg::host_op_e op, input logic [7:0] c,
                      input logic [23:0] a, input logic [7:0] d);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_op    <= op;
    req_cmd   <= c;
    req_addr  <= a;
    req_data  <= d;
    do @(negedge ref_clk); while (req_ready !== 1'b1);
    @(posedge ref_clk);
    req_valid <= 1'b0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 1000);
    @(posedge ref_clk);
  endtask : xfer

  task automatic cmd(input logic [7:0] c);
    xfer(flash_sr4_pkg::OP_CMD_ONLY, c, 24'h000000, 8'h00);
  endtask : cmd

  task automatic rd(input logic [7:0] e);
    exp_q.push_back(e);
    xfer(flash_sr4_pkg::OP_CMD_RD, `CMD_READ_SR4, 24'h000000, 8'h00);
  endtask : rd

  task automatic wr4(input logic [7:0] d);
    xfer(flash_sr4_pkg::OP_CMD_WR, `CMD_WRITE_SR4, 24'h000000, d);
    sr[7] = d[7];
    sr[3] = d[3];
  endtask : wr4

  task automatic note(input string s);
    $display("test %s done", s);
  endtask : note

  always @(negedge ref_clk) begin
    if (rsp_valid === 1'b1) begin
      e_now = (exp_q.size() == 0) ? ~rsp_data : exp_q.pop_front();
      `CHK(rsp_data, e_now)
    end
  end

  // the whole run needs about 5000 cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      final_report();
    end
  end

  initial begin
    // a real falling edge, so every asynchronous reset fires
    arst_n <= 1'b0;
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(sr);
    `CHK(status_out, sr)
    repeat (3) begin
      seed = lfsr(seed);
      xfer(flash_sr4_pkg::OP_CMD_WR, `CMD_SET_WRAP, 24'h000000, seed[7:0]);
      sr[2:0] = seed[6:4];
      rd(sr);
    end
    wr4(8'hFF);
    rd(sr);
    wr4(8'h00);
    rd(sr);
    note("register");
    prog_fail <= 1'b1;
    @(posedge ref_clk);
    prog_fail <= 1'b0;
    sr[5] = 1'b1;
    rd(sr);
    erase_fail <= 1'b1;
    @(posedge ref_clk);
    erase_fail <= 1'b0;
    sr[4] = 1'b1;
    rd(sr);
    cmd(`CMD_CLEAR_ERR);
    sr[5:4] = 2'b00;
    rd(sr);
    note("fail flags");
    for (int i = 0; i < 3; i++) begin
      wr4(pd_d[i]);
      cmd(pd_c[i]);
      @(negedge ref_clk);
      `CHK({deep_sleep, ultra_deep_sleep, sram_lost}, pd_e[i])
      // a whole frame that is not the release only toggles select
      cmd(`CMD_CLEAR_ERR);
      rd(8'hFF);
      cmd(`CMD_RELEASE);
      @(negedge ref_clk);
      `CHK({deep_sleep, ultra_deep_sleep}, 2'b00)
    end
    note("power down");
    seed = lfsr(seed);
    xfer(flash_sr4_pkg::OP_CMD_ADDR_WR, `CMD_SEQ_PROG, seed[31:8], seed[7:0]);
    sr[6] = 1'b1;
    rd(sr);
    `CHK(sram_lost, 1'b0)
    xfer(flash_sr4_pkg::OP_CMD_WR, `CMD_SEQ_PROG, 24'h000000, seed[15:8]);
    rd(sr);
    cmd(`CMD_SEQ_EXIT);
    sr[6] = 1'b0;
    rd(sr);
    note("sequential");
    quad_enable_bit <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      if (i == 2) wr4(8'h08);
      seed = lfsr(seed);
      exp_q.push_back(seed[7:0]);
      xfer(i < 3 ? flash_sr4_pkg::OP_QREAD : flash_sr4_pkg::OP_QREAD_NOCMD,
           i[0] ? `CMD_QREAD_A : `CMD_QREAD_B, seed[23:0], 8'h00);
    end
    `CHK(status_out, sr)
    note("continuous read");
    final_report();
  end
endmodule : tb_flash_status_reg4_ctrl
